// >>> src/ppm_pkg.sv
// shared constants for the port pin function multiplexer
package ppm_pkg;
    localparam int PORT_W = 8;
    // pin positions
    localparam int PA_AN0 = 0;
    localparam int PA_SYNC = 1;
    localparam int PA_T0 = 2;
    localparam int PA_OD4 = 4;
    localparam int PA_IN5 = 5;
    localparam int PA_PGD = 6;
    localparam int PA_SCL = 7;
    localparam int PB_SDA = 0;
    localparam int PB_EA = 1;
    localparam int PB_PGD = 4;
    localparam int PB_ALT = 5;
    // analog channel to pin maps
    localparam logic [7:0] PA_AN_MASK = 8'h0F;
    localparam logic [7:0] PB_AN_MASK = 8'h36;
    // pin masks: weak pull-up / open-drain drivers, large-package, input-only and absent pins
    localparam logic [7:0] PA_PU_MASK = 8'h2F;
    localparam logic [7:0] PB_PU_MASK = 8'hF6;
    localparam logic [7:0] PA_OD_MASK = 8'h90;
    localparam logic [7:0] PB_OD_MASK = 8'h01;
    localparam logic [7:0] PB_BIG_MASK = 8'hF0;
    localparam logic [7:0] PA_NODRV_MASK = 8'h20;
    localparam logic [7:0] PB_ABSENT_MASK = 8'h08;
    // multi-role field
    localparam int ROLE_W = 3;
    localparam logic [2:0] ROLE_STANDALONE = 3'h0;
    localparam logic [2:0] ROLE_DIR_BIT = 3'h0;
    // reset values
    localparam logic [7:0] DIR_RST = 8'hFF;
    localparam logic [7:0] ZERO8 = 8'h00;
endpackage

// >>> src/ppm_ioc.sv
// interrupt-on-change detector for one port
`timescale 1ns/1ps
module ppm_ioc
    import ppm_pkg::*;
#(
    parameter int W = PORT_W
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // pin levels and masks
    input wire logic [W-1:0] level,
    input wire logic [W-1:0] enable,
    input wire logic [W-1:0] clear,
    // sticky change flags
    output logic [W-1:0] flag
);
    logic [W-1:0] last_r;
    logic [W-1:0] flag_r;
    logic [W-1:0] flag_nxt;
    logic [1:0] prime_r;
    logic armed;
    // the first two samples after reset hold no real history, so a pin idling high
    // would look like an edge; compares wait until both samples are real
    // limitation: a change inside those first cycles is not flagged
    assign armed = prime_r[1];
    // a change seen in the clearing cycle survives: set wins over clear
    assign flag_nxt = (flag_r & ~clear) | (enable & (level ^ last_r) & {W{armed}});
    assign flag = flag_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            last_r <= '0;
            flag_r <= '0;
            prime_r <= 2'h0;
        end else begin
            last_r <= level;
            flag_r <= flag_nxt;
            prime_r <= {prime_r[0], 1'b1};
        end
    end
endmodule

// >>> src/ppm_divsync.sv
// registered pad output stage for one port
`timescale 1ns/1ps
module ppm_divsync
    import ppm_pkg::*;
#(
    parameter int W = PORT_W
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // next pad state
    input wire logic [W-1:0] out_nxt,
    input wire logic [W-1:0] oe_n_nxt,
    // registered pad state
    output logic [W-1:0] out_q,
    output logic [W-1:0] oe_n_q
);
    // pads start released so nothing is driven before software sets up
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_q <= '0;
            oe_n_q <= '1;
        end else begin
            out_q <= out_nxt;
            oe_n_q <= oe_n_nxt;
        end
    end
endmodule

// >>> src/ppm_top.sv
// port A / port B pin function multiplexer, top level
`timescale 1ns/1ps
module ppm_top
    import ppm_pkg::*;
#(
    parameter bit LARGE_PKG = 1'b1
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // port A pads
    input wire logic [7:0] PORT_A_IN,
    output logic [7:0] PORT_A_OUT,
    output logic [7:0] PORT_A_OE_N,
    output logic [7:0] PORT_A_PULLUP,
    // port B pads
    input wire logic [7:0] PORT_B_IN,
    output logic [7:0] PORT_B_OUT,
    output logic [7:0] PORT_B_OE_N,
    output logic [7:0] PORT_B_PULLUP,
    // port configuration (1 = input)
    input wire logic [7:0] PORT_A_DIRECTION,
    input wire logic [7:0] PORT_B_DIRECTION,
    input wire logic [7:0] PORT_A_DATA,
    input wire logic [7:0] PORT_B_DATA,
    input wire logic [7:0] PORT_A_ANALOG_SELECT,
    input wire logic [7:0] PORT_B_ANALOG_SELECT,
    input wire logic [7:0] PORT_A_PULLUP_EN,
    input wire logic [7:0] PORT_B_PULLUP_EN,
    input wire logic [7:0] PORT_A_IOC_EN,
    input wire logic [7:0] PORT_B_IOC_EN,
    input wire logic [7:0] PORT_A_IOC_CLR,
    input wire logic [7:0] PORT_B_IOC_CLR,
    // alternate function controls
    input wire logic ANALOG_BENCHMARK_ENABLE,
    input wire logic [2:0] MULTI_ROLE_SELECT,
    input wire logic SYNC_IS_OUTPUT,
    input wire logic USE_ALTERNATE_SYNC_CLOCK_PIN,
    input wire logic TIMER0_SOURCE_SELECT,
    input wire logic EXTERNAL_INTERRUPT_ENABLE,
    input wire logic I2C_ENABLE,
    input wire logic PROGRAM_MODE,
    // peripheral side signals
    input wire logic SYNC_CLOCK_OUT,
    input wire logic ERROR_AMP_IS_OUTPUT,
    input wire logic I2C_SCL_DRIVE_LOW,
    input wire logic I2C_SDA_DRIVE_LOW,
    input wire logic PROGRAM_DATA_OUT,
    input wire logic PROGRAM_DATA_OE,
    output logic SYNC_CLOCK_IN,
    output logic TIMER0_EXTERNAL_CLOCK,
    output logic EXTERNAL_INTERRUPT,
    output logic I2C_SCL_IN,
    output logic I2C_SDA_IN,
    output logic PROGRAM_DATA_IN,
    output logic PROGRAM_CLOCK_IN,
    // analog switch controls
    output logic [7:0] ADC_CHANNEL_CONNECT,
    output logic ANALOG_TEST_OUT_EN,
    output logic ERROR_AMP_PIN_CONNECT,
    output logic ERROR_AMP_DRIVE_EN,
    // change flags
    output logic [7:0] PORT_A_IOC_FLAG,
    output logic [7:0] PORT_B_IOC_FLAG
);
    logic [7:0] present_b;
    logic multi_on;
    logic sync_on_b;
    logic [7:0] an_a;
    logic [7:0] an_b;
    logic [7:0] a_out_nxt;
    logic [7:0] a_oe_n_nxt;
    logic [7:0] b_out_nxt;
    logic [7:0] b_oe_n_nxt;
    logic [7:0] a_gp_oe_n;
    logic [7:0] b_gp_oe_n;
    logic [7:0] ain_q;
    logic [7:0] bin_q;
    logic [7:0] a_alt_ana;
    logic [7:0] b_alt_ana;
    logic pgm_dat_a;
    logic pgm_dat_b;
    logic dat_drv;
    logic [7:0] cfg_oe_a;

    // bonded pins: large package adds port B 4-7; bit 3 never exists
    assign present_b = (LARGE_PKG ? 8'hFF : ~PB_BIG_MASK) & ~PB_ABSENT_MASK;
    assign multi_on = (MULTI_ROLE_SELECT != ROLE_STANDALONE);
    assign sync_on_b = multi_on & USE_ALTERNATE_SYNC_CLOCK_PIN & LARGE_PKG;

    // analog connection needs both the input direction and the analog select bit
    assign an_a = PORT_A_DIRECTION & PORT_A_ANALOG_SELECT & PA_AN_MASK;
    assign an_b = PORT_B_DIRECTION & PORT_B_ANALOG_SELECT & PB_AN_MASK & present_b;
    assign ADC_CHANNEL_CONNECT = {an_b[5], an_b[4], an_b[2], an_b[1], an_a[3:0]};
    assign ANALOG_TEST_OUT_EN = ANALOG_BENCHMARK_ENABLE;
    assign ERROR_AMP_PIN_CONNECT = multi_on;
    assign ERROR_AMP_DRIVE_EN = multi_on & ERROR_AMP_IS_OUTPUT;

    // analog-owned pins keep port data drivers off; the sync clock and programming data overrides below can still drive them
    assign a_alt_ana = an_a | ({7'h00, ANALOG_BENCHMARK_ENABLE} << PA_AN0)
        | ({7'h00, multi_on & ~USE_ALTERNATE_SYNC_CLOCK_PIN & ~SYNC_IS_OUTPUT} << PA_SYNC);
    assign b_alt_ana = an_b | ({7'h00, multi_on} << PB_EA)
        | ({7'h00, sync_on_b & ~SYNC_IS_OUTPUT} << PB_ALT);

    // programming lines move with the package size
    assign pgm_dat_a = PROGRAM_MODE & ~LARGE_PKG;
    assign pgm_dat_b = PROGRAM_MODE & LARGE_PKG;
    assign dat_drv = PROGRAM_DATA_OE;

    // general purpose drive: direction bit low means drive
    assign a_gp_oe_n = PORT_A_DIRECTION | PA_NODRV_MASK;
    assign b_gp_oe_n = PORT_B_DIRECTION | ~present_b;
    assign cfg_oe_a = a_gp_oe_n | a_alt_ana;

    // port A pad selection, alternate functions override port data
    always_comb begin
        a_out_nxt = PORT_A_DATA;
        a_oe_n_nxt = cfg_oe_a;
        // open drain pins only ever pull low
        a_out_nxt = a_out_nxt & ~PA_OD_MASK;
        a_oe_n_nxt = a_oe_n_nxt | (PA_OD_MASK & PORT_A_DATA);
        if (multi_on && !USE_ALTERNATE_SYNC_CLOCK_PIN && SYNC_IS_OUTPUT) begin
            a_out_nxt[PA_SYNC] = SYNC_CLOCK_OUT;
            a_oe_n_nxt[PA_SYNC] = 1'b0;
        end
        if (TIMER0_SOURCE_SELECT || EXTERNAL_INTERRUPT_ENABLE) begin
            a_oe_n_nxt[PA_T0] = 1'b1;
        end
        if (I2C_ENABLE) begin
            a_out_nxt[PA_SCL] = 1'b0;
            a_oe_n_nxt[PA_SCL] = ~I2C_SCL_DRIVE_LOW;
        end
        if (pgm_dat_a) begin
            a_out_nxt[PA_PGD] = PROGRAM_DATA_OUT;
            a_oe_n_nxt[PA_PGD] = ~dat_drv;
            a_oe_n_nxt[PA_SCL] = 1'b1; // programming clock is input only
        end
    end

    // port B pad selection
    always_comb begin
        b_out_nxt = PORT_B_DATA & present_b;
        b_oe_n_nxt = b_gp_oe_n | b_alt_ana;
        b_out_nxt = b_out_nxt & ~PB_OD_MASK;
        b_oe_n_nxt = b_oe_n_nxt | (PB_OD_MASK & PORT_B_DATA);
        if (sync_on_b && SYNC_IS_OUTPUT) begin
            b_out_nxt[PB_ALT] = SYNC_CLOCK_OUT;
            b_oe_n_nxt[PB_ALT] = 1'b0;
        end
        if (I2C_ENABLE) begin
            b_out_nxt[PB_SDA] = 1'b0;
            b_oe_n_nxt[PB_SDA] = ~I2C_SDA_DRIVE_LOW;
        end
        if (pgm_dat_b) begin
            b_out_nxt[PB_PGD] = PROGRAM_DATA_OUT;
            b_oe_n_nxt[PB_PGD] = ~dat_drv;
            b_oe_n_nxt[PB_ALT] = 1'b1; // programming clock is input only
        end
    end

    // registered pad drivers
    ppm_divsync #(.W(PORT_W)) u_pad_a (
        .clk(CLK),
        .rst_n(RST_N),
        .out_nxt(a_out_nxt),
        .oe_n_nxt(a_oe_n_nxt),
        .out_q(PORT_A_OUT),
        .oe_n_q(PORT_A_OE_N)
    );
    ppm_divsync #(.W(PORT_W)) u_pad_b (
        .clk(CLK),
        .rst_n(RST_N),
        .out_nxt(b_out_nxt),
        .oe_n_nxt(b_oe_n_nxt),
        .out_q(PORT_B_OUT),
        .oe_n_q(PORT_B_OE_N)
    );

    // weak pull-ups only where the pad has one, and never while driving
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            PORT_A_PULLUP <= ZERO8;
            PORT_B_PULLUP <= ZERO8;
        end else begin
            PORT_A_PULLUP <= PORT_A_PULLUP_EN & PA_PU_MASK & a_oe_n_nxt;
            PORT_B_PULLUP <= PORT_B_PULLUP_EN & PB_PU_MASK & present_b & b_oe_n_nxt;
        end
    end

    // input sampling; absent pins read zero
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ain_q <= ZERO8;
            bin_q <= ZERO8;
        end else begin
            ain_q <= PORT_A_IN;
            bin_q <= PORT_B_IN & present_b;
        end
    end

    // peripheral inputs gated by their enables
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            SYNC_CLOCK_IN <= 1'b0;
            TIMER0_EXTERNAL_CLOCK <= 1'b0;
            EXTERNAL_INTERRUPT <= 1'b0;
            I2C_SCL_IN <= 1'b1;
            I2C_SDA_IN <= 1'b1;
            PROGRAM_DATA_IN <= 1'b0;
            PROGRAM_CLOCK_IN <= 1'b0;
        end else begin
            SYNC_CLOCK_IN <= multi_on & (sync_on_b ? PORT_B_IN[PB_ALT] : PORT_A_IN[PA_SYNC]);
            TIMER0_EXTERNAL_CLOCK <= TIMER0_SOURCE_SELECT & PORT_A_IN[PA_T0];
            EXTERNAL_INTERRUPT <= EXTERNAL_INTERRUPT_ENABLE & PORT_A_IN[PA_T0];
            I2C_SCL_IN <= ~I2C_ENABLE | PORT_A_IN[PA_SCL];
            I2C_SDA_IN <= ~I2C_ENABLE | PORT_B_IN[PB_SDA];
            PROGRAM_DATA_IN <= LARGE_PKG ? (pgm_dat_b & PORT_B_IN[PB_PGD])
                : (pgm_dat_a & PORT_A_IN[PA_PGD]);
            PROGRAM_CLOCK_IN <= LARGE_PKG ? (pgm_dat_b & PORT_B_IN[PB_ALT])
                : (pgm_dat_a & PORT_A_IN[PA_SCL]);
        end
    end

    // change detection keeps watching pins even under alternate functions
    ppm_ioc #(.W(PORT_W)) u_ioc_a (
        .clk(CLK),
        .rst_n(RST_N),
        .level(ain_q),
        .enable(PORT_A_IOC_EN),
        .clear(PORT_A_IOC_CLR),
        .flag(PORT_A_IOC_FLAG)
    );
    ppm_ioc #(.W(PORT_W)) u_ioc_b (
        .clk(CLK),
        .rst_n(RST_N),
        .level(bin_q),
        .enable(PORT_B_IOC_EN & present_b),
        .clear(PORT_B_IOC_CLR),
        .flag(PORT_B_IOC_FLAG)
    );
endmodule

// >>> testbench/ppm_assertions.sv
// assertion checker for the port pin function multiplexer
`timescale 1ns/1ps
module ppm_chk
    import ppm_pkg::*;
#(
    parameter bit LARGE_PKG = 1'b1
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // pads
    input wire logic [7:0] PORT_A_IN,
    input wire logic [7:0] PORT_A_OUT,
    input wire logic [7:0] PORT_A_OE_N,
    input wire logic [7:0] PORT_A_PULLUP,
    input wire logic [7:0] PORT_B_OUT,
    input wire logic [7:0] PORT_B_PULLUP,
    // configuration
    input wire logic [7:0] PORT_A_DIRECTION,
    input wire logic [7:0] PORT_B_DIRECTION,
    input wire logic [7:0] PORT_A_DATA,
    input wire logic [7:0] PORT_A_ANALOG_SELECT,
    input wire logic [7:0] PORT_B_ANALOG_SELECT,
    input wire logic [7:0] PORT_A_IOC_EN,
    input wire logic ANALOG_BENCHMARK_ENABLE,
    input wire logic [2:0] MULTI_ROLE_SELECT,
    input wire logic PROGRAM_MODE,
    // watched outputs
    input wire logic [7:0] ADC_CHANNEL_CONNECT,
    input wire logic ANALOG_TEST_OUT_EN,
    input wire logic ERROR_AMP_PIN_CONNECT,
    input wire logic [7:0] PORT_A_IOC_FLAG
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    // analog pick of port B, the upper pair only exists on the large package
    wire logic [7:0] bsel = PORT_B_DIRECTION & PORT_B_ANALOG_SELECT;
    AST_A5_NODRV: assert property (PORT_A_OE_N[5])
        else $error("input-only pin driven");
    AST_NO_PU: assert property ((PORT_A_PULLUP & 8'hD0) == 8'h00 && !PORT_B_PULLUP[0])
        else $error("pull-up on a pin without one");
    AST_OD_LOW: assert property ((PORT_A_OUT & 8'h90) == 8'h00 && !PORT_B_OUT[0])
        else $error("open-drain pin drives high");
    AST_ADC_A: assert property (ADC_CHANNEL_CONNECT[3:0] == (PORT_A_DIRECTION[3:0] & PORT_A_ANALOG_SELECT[3:0]))
        else $error("port a analog connect wrong");
    AST_ADC_B: assert property (ADC_CHANNEL_CONNECT[7:4] == {bsel[5] & LARGE_PKG, bsel[4] & LARGE_PKG, bsel[2], bsel[1]})
        else $error("port b analog connect wrong");
    AST_BENCH: assert property (ANALOG_TEST_OUT_EN == ANALOG_BENCHMARK_ENABLE)
        else $error("test buffer enable wrong");
    AST_ROLE: assert property (ERROR_AMP_PIN_CONNECT == (MULTI_ROLE_SELECT != 3'h0))
        else $error("error amp connect wrong");
    AST_A4_OE: assert property ($past(RST_N) |-> PORT_A_OE_N[4] == ($past(PORT_A_DIRECTION[4]) | $past(PORT_A_DATA[4])))
        else $error("open-drain enable wrong");
    AST_A6_GP: assert property ($past(RST_N) && !$past(PORT_A_DIRECTION[6]) && !$past(PROGRAM_MODE)
        |-> !PORT_A_OE_N[6] && PORT_A_OUT[6] == $past(PORT_A_DATA[6]))
        else $error("push-pull pin wrong");
    AST_IOC: assert property ($past(RST_N) && $changed(PORT_A_IN[4]) && PORT_A_IOC_EN[4]
        |-> ##[1:3] PORT_A_IOC_FLAG[4])
        else $error("change flag missing");
    // main scenarios
    COV_BENCH: cover property (ANALOG_TEST_OUT_EN);
    COV_ROLE: cover property (ERROR_AMP_PIN_CONNECT);
    COV_IOC: cover property (PORT_A_IOC_FLAG[4]);
endmodule
bind ppm_top ppm_chk #(.LARGE_PKG(LARGE_PKG)) u_chk (.*);

// >>> testbench/ppm_board.sv
// board model: resolves each pad from device drive, external source and pull-up
`timescale 1ns/1ps
module ppm_board (
    // device side
    input wire logic [7:0] pad_out,
    input wire logic [7:0] pad_oe_n,
    input wire logic [7:0] pad_pu,
    // external sources
    input wire logic [7:0] ext_val,
    input wire logic [7:0] ext_en,
    // level seen by the device
    output logic [7:0] pad_level
);
    // a floating pad shows the inverse of the last data so a stale read never passes
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!pad_oe_n[i]) pad_level[i] = pad_out[i];
            else if (ext_en[i]) pad_level[i] = ext_val[i];
            else if (pad_pu[i]) pad_level[i] = 1'b1;
            else pad_level[i] = ~pad_out[i];
        end
    end
endmodule

// >>> testbench/tb.sv
// self-checking testbench for the port pin function multiplexer
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] ad, bd, adt, bdt, aa, ba, apu, bpu, aie, bie, acl, bcl, aev, aee, bev, bee;
    logic bnch, syo, alt, t0, external_interrupt_enable, i2c, prog, sck, eao, scl, sda, pdo, pdoe;
    logic [2:0] role;
    wire logic [7:0] ain, bin, aout, aoe, apo, bout, boe, bpo, adc, afl, bfl;
    wire logic syi, t0i, exi, scli, sdai, pdi, pci, ten, eac, ead;
    int n_mismatch = 0;
    int samples_checked = 0;
    always #2.5 clk = ~clk;
    ppm_top u_dut (.CLK(clk), .RST_N(rst_n), .PORT_A_IN(ain), .PORT_A_OUT(aout), .PORT_A_OE_N(aoe),
        .PORT_A_PULLUP(apo), .PORT_B_IN(bin), .PORT_B_OUT(bout), .PORT_B_OE_N(boe), .PORT_B_PULLUP(bpo),
        .PORT_A_DIRECTION(ad), .PORT_B_DIRECTION(bd), .PORT_A_DATA(adt), .PORT_B_DATA(bdt),
        .PORT_A_ANALOG_SELECT(aa), .PORT_B_ANALOG_SELECT(ba), .PORT_A_PULLUP_EN(apu), .PORT_B_PULLUP_EN(bpu),
        .PORT_A_IOC_EN(aie), .PORT_B_IOC_EN(bie), .PORT_A_IOC_CLR(acl), .PORT_B_IOC_CLR(bcl),
        .ANALOG_BENCHMARK_ENABLE(bnch), .MULTI_ROLE_SELECT(role), .SYNC_IS_OUTPUT(syo),
        .USE_ALTERNATE_SYNC_CLOCK_PIN(alt), .TIMER0_SOURCE_SELECT(t0), .EXTERNAL_INTERRUPT_ENABLE(external_interrupt_enable),
        .I2C_ENABLE(i2c), .PROGRAM_MODE(prog), .SYNC_CLOCK_OUT(sck), .ERROR_AMP_IS_OUTPUT(eao),
        .I2C_SCL_DRIVE_LOW(scl), .I2C_SDA_DRIVE_LOW(sda), .PROGRAM_DATA_OUT(pdo), .PROGRAM_DATA_OE(pdoe),
        .SYNC_CLOCK_IN(syi), .TIMER0_EXTERNAL_CLOCK(t0i), .EXTERNAL_INTERRUPT(exi), .I2C_SCL_IN(scli),
        .I2C_SDA_IN(sdai), .PROGRAM_DATA_IN(pdi), .PROGRAM_CLOCK_IN(pci), .ADC_CHANNEL_CONNECT(adc),
        .ANALOG_TEST_OUT_EN(ten), .ERROR_AMP_PIN_CONNECT(eac), .ERROR_AMP_DRIVE_EN(ead),
        .PORT_A_IOC_FLAG(afl), .PORT_B_IOC_FLAG(bfl));
    ppm_board u_pa (.pad_out(aout), .pad_oe_n(aoe), .pad_pu(apo), .ext_val(aev), .ext_en(aee), .pad_level(ain));
    ppm_board u_pb (.pad_out(bout), .pad_oe_n(boe), .pad_pu(bpo), .ext_val(bev), .ext_en(bee), .pad_level(bin));
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    // analog picks are combinational, so check a moment after the change
    task automatic adc_case(input logic [7:0] d_a, d_b, s_a, s_b, ex);
        ad = d_a;
        bd = d_b;
        aa = s_a;
        ba = s_b;
        #1 chk("adc", ex, adc);
        tick(1);
    endtask
    task automatic test_done();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // hang guard
    initial begin
        #100us;
        n_mismatch++;
        test_done();
    end
    initial begin
        {bnch, syo, alt, t0, external_interrupt_enable, i2c, prog, sck, eao, scl, sda, pdo, pdoe} = 13'h0000;
        role = 3'h0;
        {adt, bdt, aa, ba, acl, bcl, aev, aee, bev, bee} = 80'h0;
        {ad, bd, apu, bpu, aie, bie} = {6{8'hFF}};
        repeat (4) @(posedge clk);
        chk("rst_a_oe_n", 8'hFF, aoe);
        chk("rst_scl_in", 8'h01, {7'h00, scli});
        @(negedge clk) rst_n = 1'b1;
        tick(2);
        chk("a_pullup", 8'h2F, apo);
        chk("b_pullup", 8'hF6, bpo);
        {ad, bd, adt} = {8'h00, 8'h00, 8'hAA};
        tick(1);
        chk("a_oe_n", 8'hA0, aoe);
        chk("a_out", 8'h0A, aout & 8'hDF);
        chk("a_pullup_drv", 8'h20, apo);
        chk("b_oe_n", 8'h08, boe);
        adc_case(8'hFF, 8'hFF, 8'h0F, 8'h36, 8'hFF);
        adc_case(8'hFE, 8'hDF, 8'h0F, 8'h36, 8'h7E);
        adc_case(8'hFF, 8'hFF, 8'h05, 8'h12, 8'h55);
        adc_case(8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
        bnch = 1'b1;
        #1 chk("test_en", 8'h01, {7'h00, ten});
        tick(1);
        chk("a0_oe_n", 8'h01, {7'h00, aoe[0]});
        bnch = 1'b0;
        for (int r = 0; r < 8; r++) begin
            role = r[2:0];
            #1 chk("ea_con", {7'h00, r != 0}, {7'h00, eac});
            tick(1);
        end
        tick(1);
        {role, syo, sck, eao} = {3'h1, 3'b111};
        tick(1);
        chk("a1_oe_out", 8'h01, {6'h00, aoe[1], aout[1]});
        chk("ea_drv", 8'h01, {7'h00, ead});
        alt = 1'b1;
        tick(1);
        chk("b5_oe_out", 8'h01, {6'h00, boe[5], bout[5]});
        {alt, syo, aee[1], aev[1]} = 4'b0011;
        tick(2);
        chk("sync_in", 8'h01, {7'h00, syi});
        {role, aee[1], t0, external_interrupt_enable, ad, bd} = {3'h0, 3'b011, 16'hFFFF};
        {aee[2], aev[2]} = 2'b11;
        tick(2);
        chk("t0_int", 8'h03, {6'h00, t0i, exi});
        aev[2] = 1'b0;
        tick(2);
        chk("t0_int_low", 8'h00, {6'h00, t0i, exi});
        {t0, external_interrupt_enable, i2c, scl, sda} = 5'b00111;
        tick(1);
        chk("i2c_oe_n", 8'h00, {6'h00, aoe[7], boe[0]});
        {scl, sda, aee[7], aev[7], bee[0], bev[0]} = 6'b001010;
        tick(2);
        chk("scl_in", 8'h00, {7'h00, scli});
        chk("sda_in", 8'h00, {7'h00, sdai});
        chk("b0_flag", 8'h01, {7'h00, bfl[0]});
        {i2c, aee[4], aev[4]} = 3'b011;
        tick(3);
        acl = 8'hFF;
        tick(1);
        acl = 8'h00;
        tick(1);
        chk("a4_flag_clr", 8'h00, {7'h00, afl[4]});
        aev[4] = 1'b0;
        tick(3);
        chk("a4_flag", 8'h01, {7'h00, afl[4]});
        {prog, bee, bev, pdo, pdoe} = {1'b1, 8'h30, 8'h30, 2'b11};
        tick(2);
        chk("prog_lines", 8'h03, {6'h00, pdi, pci});
        chk("prog_drive", 8'h01, {6'h00, boe[4], bout[4]});
        prog = 1'b0;
        rst_n = 1'b0;
        tick(1);
        chk("rst2_a_oe_n", 8'hFF, aoe);
        rst_n = 1'b1;
        tick(2);
        chk("rst2_a_pullup", 8'h2F, apo);
        tick(1);
        chk("rst2_a_flag", 8'h00, afl);
        test_done();
    end
endmodule
